// *** logic/ebmc_pkg.sv ***
package ebmc_pkg;

   // ************************************************************
   // Execution context and sequencing
   // ************************************************************
   typedef enum logic [2:0] {
      EBMC_FG,
      EBMC_WAIT_MOVE,
      EBMC_ENTER,
      EBMC_BG,
      EBMC_EXIT
   } ebmc_state_t;

   localparam int          ADDR_W          = 24;
   localparam int          IRQ_W           = 8;
   localparam int          WDT_W           = 16;
   localparam logic [15:0] WDT_RESET_VALUE = 16'h0000;
   localparam logic [3:0]  HWSTBY_RST_CYC  = 4'h8;

   // ************************************************************
   // Grouped carriers
   // ************************************************************
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] next_pc;
   } ebmc_lp_t;

   typedef struct packed {
      logic             take;
      logic [IRQ_W-1:0] lines;
   } ebmc_irq_t;

endpackage

// *** logic/ebmc_sync.sv ***
module ebmc_sync (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_level
);

   // ************************************************************
   // Three-stage capture; a change counts when stages two and three agree.
   // ************************************************************
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end

endmodule

// *** logic/ebmc_ctrl.sv ***
// Behaviour
// - A break that arrives during a block move waits until that instruction is completely finished.
// - The watchdog count is frozen while the monitor runs and counts only in foreground.
// - A break taken from low power saves the address right after the instruction that entered it.
// - No interrupt is accepted in the monitor, and requests raised there are kept pending.
// - Interrupts kept pending in the monitor are taken on return to the foreground.
module ebmc_ctrl (
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_break_req,
   input  wire logic                       i_block_move_instruction,
   input  wire logic                       i_monitor_exit,
   input  wire logic                       i_sleep,
   input  wire logic                       i_sw_standby,
   input  wire logic [ebmc_pkg::ADDR_W-1:0] i_lp_next_pc,
   input  wire logic                       i_hw_standby_pin,
   input  wire logic [ebmc_pkg::IRQ_W-1:0]  i_irq,
   input  wire logic                       i_irq_ack,
   output logic                            o_background,
   output logic                            o_break_taken,
   output logic                            o_lowpower_release,
   output logic [ebmc_pkg::ADDR_W-1:0]      o_saved_pc,
   output logic                            o_saved_pc_valid,
   output logic                            o_cpu_reset,
   output logic [ebmc_pkg::WDT_W-1:0]       o_wdt_count,
   output logic [ebmc_pkg::IRQ_W-1:0]       o_irq_deliver,
   output logic                            o_irq_take
);

   // ************************************************************
   // Declarations
   // ************************************************************
   ebmc_pkg::ebmc_state_t             state_q;
   logic                              brk_pend_q;
   logic                              hwstby_lvl;
   logic                              hwstby_d1_q;
   logic [3:0]                        rst_cnt_q;
   logic [ebmc_pkg::IRQ_W-1:0]        irq_pend_q;
   ebmc_pkg::ebmc_lp_t                lp_q;
   ebmc_pkg::ebmc_irq_t               irq_d;
   logic                              in_lowpower;

   assign in_lowpower = i_sleep | i_sw_standby;

   ebmc_sync u_hwstby_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async (i_hw_standby_pin),
      .o_level (hwstby_lvl)
   );

   // ************************************************************
   // Hardware standby becomes a timed processor reset
   // ************************************************************
   // The reset is stretched so that a short standby pulse still clears the core fully.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hwstby_d1_q <= 1'b0;
         rst_cnt_q   <= 4'h0;
         o_cpu_reset <= 1'b0;
      end else begin
         hwstby_d1_q <= hwstby_lvl;
         if (hwstby_lvl && !hwstby_d1_q) begin
            rst_cnt_q <= ebmc_pkg::HWSTBY_RST_CYC;
         end else if (rst_cnt_q != 4'h0 && !hwstby_lvl) begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
         end
         o_cpu_reset <= hwstby_lvl || (rst_cnt_q != 4'h0);
      end
   end

   // ************************************************************
   // Break request holding
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         brk_pend_q <= 1'b0;
      end else if (i_break_req && (state_q == ebmc_pkg::EBMC_FG || state_q == ebmc_pkg::EBMC_EXIT)) begin
         // The exit cycle is already foreground, so a break raised there is latched rather than lost.
         brk_pend_q <= 1'b1;
      end else if (state_q == ebmc_pkg::EBMC_ENTER) begin
         brk_pend_q <= 1'b0;
      end
   end

   // ************************************************************
   // Context state machine
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         state_q <= ebmc_pkg::EBMC_FG;
      end else begin
         case (state_q)
            ebmc_pkg::EBMC_FG: begin
               if (i_break_req || brk_pend_q) begin
                  if (i_block_move_instruction) begin
                     state_q <= ebmc_pkg::EBMC_WAIT_MOVE;
                  end else begin
                     state_q <= ebmc_pkg::EBMC_ENTER;
                  end
               end
            end
            ebmc_pkg::EBMC_WAIT_MOVE: begin
               if (!i_block_move_instruction) begin
                  state_q <= ebmc_pkg::EBMC_ENTER;
               end
            end
            ebmc_pkg::EBMC_ENTER: begin
               state_q <= ebmc_pkg::EBMC_BG;
            end
            ebmc_pkg::EBMC_BG: begin
               if (i_monitor_exit) begin
                  state_q <= ebmc_pkg::EBMC_EXIT;
               end
            end
            default: begin
               state_q <= ebmc_pkg::EBMC_FG;
            end
         endcase
      end
   end

   // Single context flag; the exit state already counts as foreground.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         o_background <= 1'b0;
      end else begin
         o_background <= (state_q == ebmc_pkg::EBMC_ENTER)
                         || (state_q == ebmc_pkg::EBMC_BG && !i_monitor_exit);
      end
   end

   // ************************************************************
   // Monitor entry: break pulse, low-power release, saved address
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         o_break_taken      <= 1'b0;
         o_lowpower_release <= 1'b0;
         lp_q               <= '0;
      end else begin
         o_break_taken      <= (state_q == ebmc_pkg::EBMC_ENTER);
         o_lowpower_release <= (state_q == ebmc_pkg::EBMC_ENTER) && in_lowpower;
         if (state_q == ebmc_pkg::EBMC_ENTER) begin
            lp_q.valid   <= in_lowpower;
            lp_q.next_pc <= in_lowpower ? i_lp_next_pc : '0;
         end
      end
   end

   assign o_saved_pc       = lp_q.next_pc;
   assign o_saved_pc_valid = lp_q.valid;

   // ************************************************************
   // Watchdog count gated by context
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         o_wdt_count <= ebmc_pkg::WDT_RESET_VALUE;
      end else if (!o_background) begin
         o_wdt_count <= o_wdt_count + 16'h0001;
      end
   end

   // ************************************************************
   // Interrupt holding and delivery
   // ************************************************************
   // New requests always win over the acknowledge clear in the same cycle.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         irq_pend_q <= '0;
      end else begin
         irq_pend_q <= (irq_pend_q & ~((i_irq_ack && o_irq_take) ? o_irq_deliver : '0)) | i_irq;
      end
   end

   always_comb begin
      irq_d.take  = !o_background && (irq_pend_q != '0);
      irq_d.lines = irq_d.take ? irq_pend_q : '0;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || o_cpu_reset) begin
         o_irq_take    <= 1'b0;
         o_irq_deliver <= '0;
      end else begin
         o_irq_take    <= irq_d.take && !(state_q == ebmc_pkg::EBMC_ENTER);
         o_irq_deliver <= (state_q == ebmc_pkg::EBMC_ENTER) ? '0 : irq_d.lines;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_move_holds_break: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (state_q == ebmc_pkg::EBMC_WAIT_MOVE && i_block_move_instruction) |=> !o_break_taken)
      else $error("break taken during block move");

   a_wdt_frozen_bg: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n || o_cpu_reset)
      (o_background && $past(o_background)) |-> $stable(o_wdt_count))
      else $error("watchdog moved in background");

   a_lp_release: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n || o_cpu_reset)
      (state_q == ebmc_pkg::EBMC_ENTER && in_lowpower) |=> o_lowpower_release)
      else $error("low power not released");

   a_lp_next_pc: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n || o_cpu_reset)
      (state_q == ebmc_pkg::EBMC_ENTER && in_lowpower) |=> (o_saved_pc == $past(i_lp_next_pc)))
      else $error("saved address wrong");

   a_hwstby_reset: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      hwstby_lvl |=> o_cpu_reset)
      else $error("standby did not reset");

   a_no_irq_bg: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_background |-> !o_irq_take)
      else $error("interrupt taken in background");

   a_irq_on_return: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n || o_cpu_reset)
      ($fell(o_background) && irq_pend_q != '0) |=> o_irq_take)
      else $error("pending interrupt not delivered");

   a_flag_single: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n || o_cpu_reset)
      $rose(o_background) |-> (($past(state_q) == ebmc_pkg::EBMC_ENTER) && o_break_taken))
      else $error("background flag without entry");

endmodule

// *** testbench/ebmc_target.sv ***
module ebmc_target (
   input  wire logic                  i_mclk,
   output logic                       o_hw_standby_pin,
   output logic [ebmc_pkg::IRQ_W-1:0] o_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // Target board pins
   // ************************************************************
   // The board only raises requests; it never masters the bus or maps memory.
   initial begin
      o_hw_standby_pin = 1'b0;
      o_irq = 8'h00;
   end
   task automatic pulse_irq(input logic [ebmc_pkg::IRQ_W-1:0] lines);
      @(negedge i_mclk);
      o_irq = lines;
      @(negedge i_mclk);
      o_irq = 8'h00;
   endtask
   task automatic set_standby(input logic level);
      @(negedge i_mclk);
      o_hw_standby_pin = level;
   endtask
endmodule

// *** testbench/tb_ebmc_ctrl.sv ***
module tb_ebmc_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // Bench
   // ************************************************************
   typedef struct packed {
      logic                        lp;
      logic [ebmc_pkg::ADDR_W-1:0] pc;
   } ebmc_exp_t;
   logic                        mclk = 1'b0;
   logic                        rst_n = 1'b0;
   logic                        brk = 1'b0, mov = 1'b0, ext = 1'b0, slp = 1'b0, sstb = 1'b0, ack = 1'b0;
   logic [ebmc_pkg::ADDR_W-1:0] pc = 24'h000000;
   logic                        hws, bg, tk, lpr, spv, crst, itk;
   logic [ebmc_pkg::IRQ_W-1:0]  irq, dlv;
   logic [ebmc_pkg::ADDR_W-1:0] spc;
   logic [ebmc_pkg::WDT_W-1:0]  wdt;
   ebmc_exp_t                   exp_q[$];
   int                          n_errors = 0;
   int                          checks_done = 0;
   int                          cycles = 0;
   always #50 mclk = ~mclk;
   ebmc_target ebmc_target_inst (.i_mclk(mclk), .o_hw_standby_pin(hws), .o_irq(irq));
   ebmc_ctrl ebmc_ctrl_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_break_req(brk), .i_block_move_instruction(mov),
      .i_monitor_exit(ext), .i_sleep(slp), .i_sw_standby(sstb), .i_lp_next_pc(pc), .i_hw_standby_pin(hws),
      .i_irq(irq), .i_irq_ack(ack), .o_background(bg), .o_break_taken(tk), .o_lowpower_release(lpr),
      .o_saved_pc(spc), .o_saved_pc_valid(spv), .o_cpu_reset(crst), .o_wdt_count(wdt),
      .o_irq_deliver(dlv), .o_irq_take(itk));
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_break(input ebmc_exp_t e);
      cmp_val("lowpower_release", {31'h0, e.lp}, {31'h0, lpr});
      cmp_val("saved_pc_valid", {31'h0, e.lp}, {31'h0, spv});
      cmp_val("saved_pc", {8'h00, e.lp ? e.pc : 24'h000000}, {8'h00, spc});
      cmp_val("background", 32'h1, {31'h0, bg});
   endtask
   // The watcher samples at the rising edge, where registered outputs are settled.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         conclude();
      end
      if (tk === 1'b1) begin
         if (exp_q.size() == 0) cmp_val("unexpected_break", 32'h0, 32'h1);
         else cmp_break(exp_q.pop_front());
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wait_sig(input string what, input int lim, input logic lvl, ref logic s);
      int i;
      for (i = 0; i < lim && s !== lvl; i++) tick(1);
      cmp_val(what, {31'h0, lvl}, {31'h0, s});
   endtask
   task automatic enter(input int mode, input int moves);
      ebmc_exp_t e;
      e.lp = (mode != 0);
      e.pc = 24'($urandom());
      pc = e.pc;
      slp = (mode == 1);
      sstb = (mode == 2);
      mov = (moves > 0);
      exp_q.push_back(e);
      brk = 1'b1;
      tick(1);
      brk = 1'b0;
      repeat (moves) begin
         tick(1);
         cmp_val("bg_during_move", 32'h0, {31'h0, bg});
      end
      mov = 1'b0;
      wait_sig("background", 10, 1'b1, bg);
      slp = 1'b0;
      sstb = 1'b0;
   endtask
   task automatic leave();
      ext = 1'b1;
      tick(1);
      ext = 1'b0;
      wait_sig("foreground", 10, 1'b0, bg);
   endtask
   initial begin
      logic [ebmc_pkg::WDT_W-1:0] w0;
      logic [ebmc_pkg::IRQ_W-1:0] pat;
      void'($urandom(44528));
      tick(6);
      rst_n = 1'b1;
      tick(2);
      for (int m = 0; m < 3; m++) begin
         enter(m, 0);
         leave();
      end
      enter(0, 7);
      w0 = wdt;
      tick(5);
      cmp_val("wdt_frozen", {16'h0, w0}, {16'h0, wdt});
      pat = 8'($urandom()) | 8'h01;
      ebmc_target_inst.pulse_irq(pat);
      tick(4);
      cmp_val("irq_take_bg", 32'h0, {31'h0, itk});
      leave();
      wait_sig("irq_take_fg", 5, 1'b1, itk);
      cmp_val("irq_deliver", {24'h0, pat}, {24'h0, dlv});
      ack = 1'b1;
      tick(1);
      ack = 1'b0;
      tick(3);
      cmp_val("irq_cleared", 32'h0, {31'h0, itk});
      w0 = wdt;
      tick(5);
      cmp_val("wdt_counts", {16'h0, w0 + 16'h0005}, {16'h0, wdt});
      enter(1, 0);
      ebmc_target_inst.set_standby(1'b1);
      wait_sig("cpu_reset", 12, 1'b1, crst);
      tick(1);
      cmp_val("bg_cleared", 32'h0, {31'h0, bg});
      ebmc_target_inst.set_standby(1'b0);
      wait_sig("cpu_reset_end", 30, 1'b0, crst);
      tick(3);
      cmp_val("breaks_left", 32'h0, exp_q.size());
      conclude();
   end
endmodule
